// file: logic/acc_adc_control.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Converts the selected input's sampled level into an 8-bit unsigned code.
// - Successive approximation on the held sample, one bit per bit period.
// - Software selects the positive reference: supply or reference pin.
// - Reset restores control registers, powers off, aborts any conversion.
// - Clock field bits 7-6: div2, div8, div32, internal RC.
// - Channel field bits 5-3 routes inputs 0 to 4 to sample-and-hold.
// - Writing go bit while powered starts conversion; reads one while busy.
// - Hardware clears the go bit when conversion finishes.
// - Pin code 000 all analog supply ref; 001 reference pin as ref.
// - Codes 100 and 101 make inputs 2 and 4 digital.
// - Completion loads result, sets flag, clears go bit together.
// - Result register is not initialised by reset.
// - A conversion takes nine and a half bit periods.
// - Special event trigger starts a conversion only while powered on.
module acc_adc_control (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic rc_clock_tick,
  input wire logic special_event_trigger,
  input wire logic comparator_high,
  output logic [7:0] dac_code,
  output logic sample_hold,
  output logic [2:0] sample_channel,
  output logic reference_from_pin,
  output logic [4:0] analog_pin_mask,
  output logic converter_power_on,
  output logic conversion_complete_flag
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [1:0] clk_sel_reg, clk_sel_next;
  logic [2:0] chan_reg, chan_next;
  logic go_reg, go_next;
  logic power_reg, power_next;
  logic [2:0] pin_func_reg, pin_func_next;
  logic flag_reg, flag_next;
  logic [7:0] result_reg, result_next;
  logic [7:0] rdata_reg, rdata_next;
  acc_pkg::acc_state_t state_reg, state_next;
  logic [7:0] sar_reg, sar_next;
  logic [7:0] trial_reg, trial_next;
  logic [4:0] half_cnt_reg, half_cnt_next;
  logic [7:0] dac_reg, dac_next;
  logic half_tick;
  logic start;

  function automatic logic [4:0] pin_mask(input logic [2:0] code);
    // Bits: input 0,1,2,3,4 analog when set.
    logic [4:0] m;
    m = 5'h00;
    unique case (code)
      3'h0, 3'h2: m = 5'h1F;
      3'h1, 3'h3: m = 5'h17;
      3'h4: m = 5'h0B;
      3'h5: m = 5'h03;
      default: m = 5'h00;
    endcase
    return m;
  endfunction

  function automatic logic ref_is_pin(input logic [2:0] code);
    return code[0] && (code != 3'h7);
  endfunction

  acc_tick_gen u_tick (
    .clock(clock),
    .nrst(nrst),
    .run(state_reg == acc_pkg::ACC_CONV),
    .clock_select(clk_sel_reg),
    .rc_clock_tick(rc_clock_tick),
    .half_tick(half_tick)
  );

  // ------------------------------------------------------------
  // Register writes and start logic
  // ------------------------------------------------------------
  always_comb begin
    clk_sel_next = clk_sel_reg;
    chan_next = chan_reg;
    power_next = power_reg;
    pin_func_next = pin_func_reg;
    flag_next = flag_reg;
    go_next = go_reg;
    start = 1'b0;
    if (wr_en && addr == acc_pkg::CONV_CONTROL_ADDR) begin
      clk_sel_next = wdata[acc_pkg::CLK_SEL_HI:acc_pkg::CLK_SEL_LO];
      chan_next = wdata[acc_pkg::CHAN_HI:acc_pkg::CHAN_LO];
      power_next = wdata[acc_pkg::POWER_BIT];
      // Go is only honoured when the converter was already powered.
      if (wdata[acc_pkg::GO_BIT] && power_reg && wdata[acc_pkg::POWER_BIT]
          && !go_reg) begin
        start = 1'b1;
      end else if (!wdata[acc_pkg::GO_BIT]) begin
        go_next = 1'b0;
      end
    end
    if (wr_en && addr == acc_pkg::PIN_FUNC_CONFIG_ADDR) begin
      pin_func_next = wdata[2:0];
    end
    if (wr_en && addr == acc_pkg::COMPLETE_FLAG_ADDR) begin
      flag_next = wdata[acc_pkg::FLAG_BIT];
    end
    if (special_event_trigger && power_reg && !go_reg) begin
      start = 1'b1;
    end
    if (start) begin
      go_next = 1'b1;
    end
    if (!power_next) begin
      go_next = 1'b0;
    end
    if (state_reg == acc_pkg::ACC_DONE) begin
      go_next = 1'b0;
      flag_next = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Successive approximation sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    sar_next = sar_reg;
    trial_next = trial_reg;
    half_cnt_next = half_cnt_reg;
    dac_next = dac_reg;
    result_next = result_reg;
    unique case (state_reg)
      acc_pkg::ACC_IDLE: begin
        if (start) begin
          state_next = acc_pkg::ACC_CONV;
          sar_next = 8'h00;
          trial_next = 8'h80;
          dac_next = 8'h80;
          half_cnt_next = 5'h00;
        end
      end
      acc_pkg::ACC_CONV: begin
        if (!go_reg || !power_reg) begin
          // Abort: software cleared go or powered the converter off.
          state_next = acc_pkg::ACC_IDLE;
        end else if (half_tick) begin
          half_cnt_next = half_cnt_reg + 5'h01;
          // Decide one bit at the end of each of the first eight whole bit periods.
          if (half_cnt_reg[0] && trial_reg != 8'h00) begin
            if (comparator_high) begin
              sar_next = sar_reg | trial_reg;
            end
            trial_next = trial_reg >> 1;
            dac_next = (comparator_high ? (sar_reg | trial_reg) : sar_reg)
                       | (trial_reg >> 1);
          end
          if (half_cnt_reg + 5'h01 == acc_pkg::CONV_HALF_PERIODS) begin
            state_next = acc_pkg::ACC_DONE;
          end
        end
      end
      acc_pkg::ACC_DONE: begin
        result_next = sar_reg;
        state_next = acc_pkg::ACC_IDLE;
      end
      default: state_next = acc_pkg::ACC_IDLE;
    endcase
  end

  always_comb begin
    rdata_next = 8'h00;
    if (rd_en) begin
      unique case (addr)
        acc_pkg::CONV_CONTROL_ADDR:
          rdata_next = {clk_sel_reg, chan_reg, go_reg, 1'b0, power_reg};
        acc_pkg::PIN_FUNC_CONFIG_ADDR: rdata_next = {5'h00, pin_func_reg};
        acc_pkg::CONV_RESULT_ADDR: rdata_next = result_reg;
        acc_pkg::COMPLETE_FLAG_ADDR: rdata_next = {1'b0, flag_reg, 6'h00};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clk_sel_reg <= 2'h0;
      chan_reg <= 3'h0;
      go_reg <= 1'b0;
      power_reg <= 1'b0;
      pin_func_reg <= acc_pkg::PIN_FUNC_RESET;
      flag_reg <= 1'b0;
      rdata_reg <= 8'h00;
      state_reg <= acc_pkg::ACC_IDLE;
      sar_reg <= 8'h00;
      trial_reg <= 8'h00;
      half_cnt_reg <= 5'h00;
      dac_reg <= 8'h00;
    end else begin
      clk_sel_reg <= clk_sel_next;
      chan_reg <= chan_next;
      go_reg <= go_next;
      power_reg <= power_next;
      pin_func_reg <= pin_func_next;
      flag_reg <= flag_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
      sar_reg <= sar_next;
      trial_reg <= trial_next;
      half_cnt_reg <= half_cnt_next;
      dac_reg <= dac_next;
    end
  end

  // The result keeps its contents through reset on purpose.
  always_ff @(posedge clock) begin
    result_reg <= result_next;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rdata = rdata_reg;
  assign dac_code = dac_reg;
  assign sample_hold = (state_reg == acc_pkg::ACC_CONV);
  assign sample_channel = (chan_reg > acc_pkg::MAX_CHANNEL) ? 3'h0 : chan_reg;
  assign reference_from_pin = ref_is_pin(pin_func_reg);
  assign analog_pin_mask = pin_mask(pin_func_reg);
  assign converter_power_on = power_reg;
  assign conversion_complete_flag = flag_reg;

endmodule

`default_nettype wire

// file: logic/acc_pkg.sv
package acc_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] CONV_CONTROL_ADDR = 8'h1F;
  localparam logic [7:0] PIN_FUNC_CONFIG_ADDR = 8'h9F;
  localparam logic [7:0] CONV_RESULT_ADDR = 8'h1E;
  localparam logic [7:0] COMPLETE_FLAG_ADDR = 8'h0C;
  localparam logic [7:0] CONV_CONTROL_RESET = 8'h00;
  localparam logic [2:0] PIN_FUNC_RESET = 3'h0;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CLK_SEL_HI = 7;
  localparam int CLK_SEL_LO = 6;
  localparam int CHAN_HI = 5;
  localparam int CHAN_LO = 3;
  localparam int GO_BIT = 2;
  localparam int POWER_BIT = 0;
  localparam int FLAG_BIT = 6;

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV8 = 2'h1;
  localparam logic [1:0] CLK_DIV32 = 2'h2;
  localparam logic [1:0] CLK_RC = 2'h3;
  localparam logic [2:0] MAX_CHANNEL = 3'h4;

  // ------------------------------------------------------------
  // Timing: oscillator periods per bit period, in half periods
  // ------------------------------------------------------------
  localparam logic [5:0] HALF_DIV2 = 6'h01;
  localparam logic [5:0] HALF_DIV8 = 6'h04;
  localparam logic [5:0] HALF_DIV32 = 6'h10;
  localparam int RESULT_BITS = 8;
  // Conversion takes 9.5 bit periods, counted as 19 half periods.
  localparam logic [4:0] CONV_HALF_PERIODS = 5'h13;

  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_CONV = 3'b010,
    ACC_DONE = 3'b100
  } acc_state_t;

endpackage

// file: logic/acc_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------
// Half bit-period tick generator
// --------------------------------------------------------------
module acc_tick_gen (
  input wire logic clock,
  input wire logic nrst,
  input wire logic run,
  input wire logic [1:0] clock_select,
  input wire logic rc_clock_tick,
  output logic half_tick
);

  logic [5:0] count_reg;
  logic [5:0] count_next;
  logic [5:0] limit;

  always_comb begin
    unique case (clock_select)
      acc_pkg::CLK_DIV2: limit = acc_pkg::HALF_DIV2;
      acc_pkg::CLK_DIV8: limit = acc_pkg::HALF_DIV8;
      acc_pkg::CLK_DIV32: limit = acc_pkg::HALF_DIV32;
      acc_pkg::CLK_RC: limit = 6'h01;
    endcase
  end

  always_comb begin
    count_next = count_reg;
    half_tick = 1'b0;
    if (!run) begin
      count_next = 6'h00;
    end else if (clock_select == acc_pkg::CLK_RC) begin
      // The RC source delivers its own half-period ticks.
      half_tick = rc_clock_tick;
    end else if (count_reg + 6'h01 >= limit) begin
      count_next = 6'h00;
      half_tick = 1'b1;
    end else begin
      count_next = count_reg + 6'h01;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_reg <= 6'h00;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

`default_nettype wire

// file: sim/acc_adc_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
module acc_adc_control_sva (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic special_event_trigger,
  input wire logic sample_hold,
  input wire logic [2:0] sample_channel,
  input wire logic converter_power_on,
  input wire logic conversion_complete_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [9:0] hold_cnt;
  // Keeps the length of the last hold so it can be judged when it ends.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hold_cnt <= 10'h000;
    end else begin
      hold_cnt <= sample_hold ? hold_cnt + 10'h001 : 10'h000;
    end
  end
  chk_write_starts: assert property (
    wr_en && addr == acc_pkg::CONV_CONTROL_ADDR && wdata[2] && wdata[0] && converter_power_on
    && !sample_hold |=> sample_hold) else $error("go write did not start");
  chk_trigger_starts: assert property (
    special_event_trigger && converter_power_on && !sample_hold |=> sample_hold)
    else $error("trigger did not start");
  chk_hold_powered: assert property ($rose(sample_hold) |-> $past(converter_power_on))
    else $error("conversion started unpowered");
  chk_off_no_hold: assert property (!converter_power_on |=> !sample_hold)
    else $error("hold while converter off");
  chk_conv_length: assert property (
    $fell(sample_hold) && !$past(wr_en) && !$past(wr_en, 2) |-> hold_cnt >= 10'h013)
    else $error("conversion too short");
  chk_flag_cause: assert property (
    $rose(conversion_complete_flag) && !$past(wr_en) |-> $past(sample_hold)
    || $past(sample_hold, 2)) else $error("flag set without conversion");
  chk_flag_kept: assert property (
    conversion_complete_flag && !wr_en |=> conversion_complete_flag)
    else $error("flag dropped by itself");
  chk_channel_range: assert property (sample_channel <= 3'h4)
    else $error("channel out of range");
endmodule
bind acc_adc_control acc_adc_control_sva chk (.clock, .nrst, .addr, .wdata, .wr_en,
  .special_event_trigger, .sample_hold, .sample_channel, .converter_power_on,
  .conversion_complete_flag);
`default_nettype wire

// file: sim/acc_adc_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module acc_adc_control_test;
  logic clock, nrst, wr_en, rd_en, rc_clock_tick, special_event_trigger;
  logic comparator_high, sample_hold, reference_from_pin, converter_power_on;
  logic conversion_complete_flag;
  logic [7:0] addr, wdata, rdata, dac_code, got;
  logic [2:0] sample_channel;
  logic [4:0] analog_pin_mask, mask;
  logic [39:0] levels = 40'hC35AFF0196;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int run_len = 0;
  int last_len = 0;
  acc_adc_control dut (.clock, .nrst, .addr, .wdata, .wr_en, .rd_en, .rdata, .rc_clock_tick,
    .special_event_trigger, .comparator_high, .dac_code, .sample_hold, .sample_channel,
    .reference_from_pin, .analog_pin_mask, .converter_power_on, .conversion_complete_flag);
  acc_analog_model model (.clock, .sample_hold, .sample_channel, .dac_code, .levels,
    .comparator_high);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ------
  // Internal RC ticks and the hang guard
  // ------
  always @(posedge clock) begin
    cycles <= cycles + 1;
    rc_clock_tick <= (cycles % 3) == 0;
    // Length of the latest hold, so the selected divider can be judged.
    run_len <= sample_hold ? run_len + 1 : 0;
    if (sample_hold) begin
      last_len <= run_len + 1;
    end
    if (cycles == 20000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 got = rdata;
    @(posedge clock);
    check(got, e);
  endtask
  task automatic fire();
    special_event_trigger <= 1'b1;
    @(posedge clock);
    special_event_trigger <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_flag();
    repeat (400) begin
      @(posedge clock);
      if (conversion_complete_flag === 1'b1) break;
    end
    repeat (3) @(posedge clock);
  endtask
  task automatic reset_values();
    rc(8'h1F, 8'h00);
    rc(8'h9F, 8'h00);
    rc(8'h55, 8'h00);
    check({3'h0, analog_pin_mask}, 8'h1F);
  endtask
  task automatic pins();
    for (int c = 0; c < 6; c++) begin
      wr(8'h9F, 8'(c));
      mask = c[2] ? 5'h0B : 5'h1F;
      mask[3] = mask[3] & ~c[0];
      rc(8'h9F, 8'(c));
      check({3'h0, analog_pin_mask}, {3'h0, mask});
      check({7'h0, reference_from_pin}, {7'h0, c[0]});
    end
    wr(8'h9F, 8'h00);
  endtask
  task automatic convert(input logic [1:0] sel, input logic [2:0] ch);
    wr(8'h1F, {sel, ch, 3'h1});
    repeat (80) @(posedge clock);
    wr(8'h1F, {sel, ch, 3'h5});
    rc(8'h1F, {sel, ch, 3'h5});
    wait_flag();
    rc(8'h1F, {sel, ch, 3'h1});
    if (sel != 2'h3) begin
      check(8'(last_len / 19), (sel == 2'h0) ? 8'h01 : (sel == 2'h1) ? 8'h04 : 8'h10);
    end
    rc(8'h1E, levels[ch * 8 +: 8]);
    rc(8'h0C, 8'h40);
    wr(8'h0C, 8'h00);
    rc(8'h0C, 8'h00);
  endtask
  task automatic trig();
    wr(8'h1F, 8'h00);
    fire();
    rc(8'h1F, 8'h00);
    wr(8'h1F, 8'h05);
    rc(8'h1F, 8'h01);
    repeat (20) @(posedge clock);
    fire();
    rc(8'h1F, 8'h05);
    wait_flag();
    rc(8'h1E, levels[7:0]);
  endtask
  task automatic reset_abort();
    wr(8'h1F, 8'h91);
    repeat (20) @(posedge clock);
    wr(8'h1F, 8'h95);
    repeat (30) @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    check({7'h0, sample_hold}, 8'h00);
    check({7'h0, converter_power_on}, 8'h00);
    rc(8'h1F, 8'h00);
    rc(8'h1E, levels[7:0]);
  endtask
  initial begin
    nrst = 1'b0;
    {wr_en, rd_en, special_event_trigger, rc_clock_tick} = 4'h0;
    {addr, wdata} = 16'h0000;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    reset_values();
    pins();
    for (int i = 0; i < 5; i++) convert(2'(i), 3'(i));
    trig();
    reset_abort();
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: sim/acc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
  input wire logic clock,
  input wire logic sample_hold,
  input wire logic [2:0] sample_channel,
  input wire logic [7:0] dac_code,
  input wire logic [39:0] levels,
  output logic comparator_high
);
  // ------
  // Sample-and-hold with comparator
  // ------
  logic [7:0] held_reg;
  // The cap tracks its input until held, so a late channel change cannot corrupt a result.
  always_ff @(posedge clock) begin
    if (!sample_hold) begin
      held_reg <= levels[sample_channel * 8 +: 8];
    end
  end
  assign comparator_high = held_reg >= dac_code;
endmodule
`default_nettype wire
